// ===== sbrst_pkg.sv
package sbrst_pkg;

    // =====================================================================
    // Port structure
    // =====================================================================
    localparam int NUM_DN = 5;
    localparam logic [2:0] UP_PORT = 3'h0;

    // =====================================================================
    // Register map (byte addresses)
    // =====================================================================
    localparam logic [7:0] OFF_UP_BRIDGE_CONTROL_REG = 8'h00;
    localparam logic [7:0] OFF_DN_BRIDGE_CONTROL_REG = 8'h04;
    localparam logic [7:0] OFF_SLOT_CTL = 8'h08;
    localparam logic [7:0] OFF_HP_CFG = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_DN_SCRATCH = 8'h14;

    // =====================================================================
    // Field positions and reset values
    // =====================================================================
    localparam int HP_MODE_LSB = 0;
    localparam int HP_P2R_LSB = 8;
    localparam int HP_R2P_LSB = 16;
    localparam int ST_UPACT_LSB = 0;
    localparam int ST_DNACT_LSB = 8;
    localparam int ST_PE_LSB = 16;
    localparam int ST_RST_LSB = 24;
    localparam logic [4:0] SLOT_CTL_RST = 5'h1F;
    localparam logic [31:0] HP_CFG_RST = 32'h00000000;
    localparam logic [31:0] DN_SCRATCH_RST = 32'h00000000;

    // =====================================================================
    // Reset output modes
    // =====================================================================
    localparam logic [1:0] MODE_PWR_EN = 2'h0;
    localparam logic [1:0] MODE_PWR_GOOD = 2'h1;
    localparam logic [1:0] MODE_HOT_RST = 2'h2;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_MHZ = 50;
    localparam int MIN_RST_US = 200;
    localparam int MIN_RST_CYC = MIN_RST_US * CLK_MHZ;
    localparam int DLY_UNIT_US = 1;
    localparam int DLY_UNIT_CYC = DLY_UNIT_US * CLK_MHZ;

    // Slot state per downstream port.
    typedef enum logic [4:0] {
        SLOT_OFF = 5'h01,
        SLOT_WAIT_PG = 5'h02,
        SLOT_P2R = 5'h04,
        SLOT_ON = 5'h08,
        SLOT_R2P = 5'h10
    } sbrst_slot_t;

    // Per-port link-side controls.
    typedef struct packed {
        logic [NUM_DN-1:0] hot_reset_ts1;
        logic [NUM_DN-1:0] flush_queue;
        logic [NUM_DN-1:0] logic_reset;
        logic [NUM_DN-1:0] ur_secondary;
    } sbrst_dn_ctl_t;

endpackage

// ===== sbrst_top.sv
`timescale 1ns/100ps

// =========================================================================
// Per-slot reset and power sequencer
// =========================================================================
module sbrst_slot (
    input wire logic core_clk, // Core clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic [1:0] mode, // Reset output mode.
    input wire logic [7:0] p2r_dly, // Power to reset delay, microseconds.
    input wire logic [7:0] r2p_dly, // Reset to power delay, microseconds.
    input wire logic power_off, // Slot power off request.
    input wire logic power_good, // Slot power good, active high.
    input wire logic hot_active, // Port hot or secondary reset active.
    output logic rst_assert, // Reset output asserted.
    output logic pwr_en // Power enable output.
);
    sbrst_pkg::sbrst_slot_t state_r;
    logic [7:0] us_cnt_r;
    logic [15:0] tick_r;
    logic [15:0] hold_r;
    logic tick;
    logic want_rst;
    logic hold_done;

    // =====================================================================
    // Timing counters
    // =====================================================================

    // Microsecond tick shared by both programmed delays.
    assign tick = (tick_r == 16'(sbrst_pkg::DLY_UNIT_CYC - 1));
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tick_r <= 16'h0000;
        end else if (tick || state_r == sbrst_pkg::SLOT_ON || state_r == sbrst_pkg::SLOT_OFF) begin
            tick_r <= 16'h0000;
        end else begin
            tick_r <= tick_r + 16'h0001;
        end
    end

    // Minimum pulse counter restarts at each assertion and only lets go when spent.
    assign hold_done = (hold_r == 16'h0000);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hold_r <= 16'(sbrst_pkg::MIN_RST_CYC - 1);
        end else if (want_rst && !rst_assert) begin
            hold_r <= 16'(sbrst_pkg::MIN_RST_CYC - 1);
        end else if (rst_assert && !hold_done) begin
            hold_r <= hold_r - 16'h0001;
        end
    end

    // =====================================================================
    // Reset output
    // =====================================================================

    // Requested reset level before the minimum width is applied.
    always_comb begin
        if (mode == sbrst_pkg::MODE_HOT_RST) begin
            want_rst = hot_active;
        end else begin
            want_rst = (state_r != sbrst_pkg::SLOT_ON);
        end
    end

    // Reset output keeps asserted until the minimum width has passed.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_assert <= 1'b1;
        end else if (want_rst) begin
            rst_assert <= 1'b1;
        end else if (hold_done) begin
            rst_assert <= 1'b0;
        end
    end

    // =====================================================================
    // Power sequencing
    // =====================================================================

    // Power sequencing state machine.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= sbrst_pkg::SLOT_OFF;
            us_cnt_r <= 8'h00;
            pwr_en <= 1'b0;
        end else begin
            case (state_r)
                sbrst_pkg::SLOT_OFF: begin
                    us_cnt_r <= 8'h00;
                    if (!power_off) begin
                        pwr_en <= 1'b1;
                        if (mode == sbrst_pkg::MODE_PWR_GOOD) begin
                            state_r <= sbrst_pkg::SLOT_WAIT_PG;
                        end else begin
                            state_r <= sbrst_pkg::SLOT_P2R;
                        end
                    end
                end
                sbrst_pkg::SLOT_WAIT_PG: begin
                    if (power_off) begin
                        state_r <= sbrst_pkg::SLOT_R2P;
                    end else if (power_good) begin
                        state_r <= sbrst_pkg::SLOT_P2R;
                    end
                end
                sbrst_pkg::SLOT_P2R: begin
                    if (power_off) begin
                        us_cnt_r <= 8'h00;
                        state_r <= sbrst_pkg::SLOT_R2P;
                    end else if (mode == sbrst_pkg::MODE_PWR_GOOD && !power_good) begin
                        us_cnt_r <= 8'h00;
                        state_r <= sbrst_pkg::SLOT_WAIT_PG;
                    end else if (us_cnt_r >= p2r_dly) begin
                        us_cnt_r <= 8'h00;
                        state_r <= sbrst_pkg::SLOT_ON;
                    end else if (tick) begin
                        us_cnt_r <= us_cnt_r + 8'h01;
                    end
                end
                sbrst_pkg::SLOT_ON: begin
                    us_cnt_r <= 8'h00;
                    if (power_off) begin
                        state_r <= sbrst_pkg::SLOT_R2P;
                    end else if (mode == sbrst_pkg::MODE_PWR_GOOD && !power_good) begin
                        state_r <= sbrst_pkg::SLOT_WAIT_PG;
                    end
                end
                sbrst_pkg::SLOT_R2P: begin
                    if (us_cnt_r >= r2p_dly) begin
                        pwr_en <= 1'b0;
                        state_r <= sbrst_pkg::SLOT_OFF;
                    end else if (tick) begin
                        us_cnt_r <= us_cnt_r + 8'h01;
                    end
                end
                default: begin
                    state_r <= sbrst_pkg::SLOT_OFF;
                    pwr_en <= 1'b0;
                end
            endcase
        end
    end
endmodule

// =========================================================================
// Secondary bus reset controller with AHB-Lite registers
// =========================================================================
module sbrst_top (
    input wire logic core_clk, // Core clock, 50 MHz.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic hsel, // AHB slave select.
    input wire logic [7:0] haddr, // AHB byte address.
    input wire logic [1:0] htrans, // AHB transfer type.
    input wire logic hwrite, // AHB write.
    input wire logic [2:0] hsize, // AHB transfer size.
    input wire logic [31:0] hwdata, // AHB write data.
    input wire logic hready, // AHB bus ready.
    output logic [31:0] hrdata, // AHB read data.
    output logic hreadyout, // AHB slave ready.
    output logic hresp, // AHB response, always OKAY.
    input wire logic [4:0] link_up, // Downstream link up per port.
    input wire logic [4:0] slot_power_good_n, // Slot power good, active low.
    output logic [4:0] slot_power_enable_out, // Slot power enable.
    output logic [4:0] slot_reset_out_n_o, // Reset output pin level, active low.
    output logic [4:0] slot_reset_out_n_oe, // Reset output pin enable.
    input wire logic [4:0] gpio_alt_en, // Pin configured for reset output.
    output sbrst_pkg::sbrst_dn_ctl_t dn_ctl, // Per-port link-side controls.
    output logic up_link_hold, // Upstream link kept up.
    output logic [4:0] cfg_blocked // SMBus access to cleared registers blocked.
);
    localparam int N = sbrst_pkg::NUM_DN;
    logic up_sbr_r;
    logic [N-1:0] dn_sbr_r;
    logic [N-1:0] slot_ctl_r;
    logic [31:0] hp_cfg_r;
    logic [31:0] dn_scratch_r;
    logic ph_act_r;
    logic ph_wr_r;
    logic [7:0] ph_addr_r;
    logic [N-1:0] port_rst;
    logic [N-1:0] rst_as;
    logic [N-1:0] pe;
    logic [1:0] mode;

    assign mode = hp_cfg_r[sbrst_pkg::HP_MODE_LSB +: 2];
    // Upstream reset hits every port; a port reset hits only its own port.
    assign port_rst = {N{up_sbr_r}} | dn_sbr_r;

    // =====================================================================
    // Bus slave
    // =====================================================================

    // Address phase capture; the slave never waits.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ph_act_r <= 1'b0;
            ph_wr_r <= 1'b0;
            ph_addr_r <= 8'h00;
        end else if (hready) begin
            ph_act_r <= hsel && htrans[1];
            ph_wr_r <= hwrite;
            ph_addr_r <= haddr;
        end
    end

    // =====================================================================
    // Registers
    // =====================================================================

    // Bridge control reset bits set and clear on software writes only.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            up_sbr_r <= 1'b0;
            dn_sbr_r <= '0;
            slot_ctl_r <= sbrst_pkg::SLOT_CTL_RST;
            hp_cfg_r <= sbrst_pkg::HP_CFG_RST;
        end else if (ph_act_r && ph_wr_r) begin
            case (ph_addr_r)
                sbrst_pkg::OFF_UP_BRIDGE_CONTROL_REG: up_sbr_r <= hwdata[0];
                sbrst_pkg::OFF_DN_BRIDGE_CONTROL_REG: dn_sbr_r <= hwdata[N-1:0];
                sbrst_pkg::OFF_SLOT_CTL: slot_ctl_r <= hwdata[N-1:0];
                sbrst_pkg::OFF_HP_CFG: hp_cfg_r <= hwdata;
                default: begin
                end
            endcase
        end
    end

    // Downstream register cleared by upstream reset; sticky bits are not here.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dn_scratch_r <= sbrst_pkg::DN_SCRATCH_RST;
        end else if (up_sbr_r) begin
            dn_scratch_r <= sbrst_pkg::DN_SCRATCH_RST;
        end else if (ph_act_r && ph_wr_r && ph_addr_r == sbrst_pkg::OFF_DN_SCRATCH) begin
            dn_scratch_r <= hwdata;
        end
    end

    // Read data mux; unmapped addresses read zero.
    always_comb begin
        hrdata = 32'h00000000;
        if (ph_act_r && !ph_wr_r) begin
            case (ph_addr_r)
                sbrst_pkg::OFF_UP_BRIDGE_CONTROL_REG: hrdata = {31'h00000000, up_sbr_r};
                sbrst_pkg::OFF_DN_BRIDGE_CONTROL_REG: hrdata = {27'h0000000, dn_sbr_r};
                sbrst_pkg::OFF_SLOT_CTL: hrdata = {27'h0000000, slot_ctl_r};
                sbrst_pkg::OFF_HP_CFG: hrdata = hp_cfg_r;
                sbrst_pkg::OFF_STATUS: begin
                    hrdata[sbrst_pkg::ST_UPACT_LSB] = up_sbr_r;
                    hrdata[sbrst_pkg::ST_DNACT_LSB +: N] = dn_sbr_r;
                    hrdata[sbrst_pkg::ST_PE_LSB +: N] = slot_power_enable_out;
                    hrdata[sbrst_pkg::ST_RST_LSB +: N] = ~slot_reset_out_n_o;
                end
                sbrst_pkg::OFF_DN_SCRATCH: hrdata = dn_scratch_r;
                default: hrdata = 32'h00000000;
            endcase
        end
    end

    // Bus answer flops; every register settles in one cycle, so no wait state is needed.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // =====================================================================
    // Link-side controls
    // =====================================================================

    // Flush, unsupported marking and link-gated hot reset sets held while each port's reset stands; logic reset on upstream reset only.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dn_ctl <= '0;
            up_link_hold <= 1'b1;
            cfg_blocked <= '0;
        end else begin
            dn_ctl.hot_reset_ts1 <= port_rst & link_up;
            dn_ctl.flush_queue <= port_rst;
            dn_ctl.logic_reset <= {N{up_sbr_r}};
            dn_ctl.ur_secondary <= port_rst;
            up_link_hold <= 1'b1;
            cfg_blocked <= {N{up_sbr_r}};
        end
    end

    // =====================================================================
    // Slot sequencers and pins
    // =====================================================================

    // One sequencer per downstream slot.
    for (genvar i = 0; i < N; i++) begin : g_slot
        sbrst_slot u_slot (
            .core_clk(core_clk),
            .nrst(nrst),
            .mode(mode),
            .p2r_dly(hp_cfg_r[sbrst_pkg::HP_P2R_LSB +: 8]),
            .r2p_dly(hp_cfg_r[sbrst_pkg::HP_R2P_LSB +: 8]),
            .power_off(slot_ctl_r[i]),
            .power_good(!slot_power_good_n[i]),
            .hot_active(port_rst[i]),
            .rst_assert(rst_as[i]),
            .pwr_en(pe[i])
        );
    end

    // Reset pins stay undriven until the alternate function is selected; power enable is always driven.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            slot_reset_out_n_o <= '0;
            slot_reset_out_n_oe <= '0;
            slot_power_enable_out <= '0;
        end else begin
            slot_reset_out_n_o <= ~rst_as;
            slot_reset_out_n_oe <= gpio_alt_en;
            slot_power_enable_out <= pe;
        end
    end
endmodule

// ===== sbrst_monitor.sv
`timescale 1ns/100ps
// =====================================================================
// Port checker for the reset controller
// =====================================================================
module sbrst_monitor (
    input wire logic core_clk, // Core clock.
    input wire logic nrst, // Reset, active low.
    input wire logic hreadyout, // Slave ready.
    input wire logic hresp, // Slave response.
    input wire logic [4:0] link_up, // Link up per port.
    input wire logic [4:0] gpio_alt_en, // Pin set as reset output.
    input wire logic [4:0] slot_power_enable_out, // Power enable.
    input wire logic [4:0] slot_reset_out_n_o, // Reset pin level.
    input wire logic [4:0] slot_reset_out_n_oe, // Reset pin enable.
    input wire sbrst_pkg::sbrst_dn_ctl_t dn_ctl, // Link controls.
    input wire logic up_link_hold, // Upstream link kept.
    input wire logic [4:0] cfg_blocked // Cleared registers blocked.
);
    // Two cycles of slack cover the output flop between count and pin.
    localparam int MIN_LOW = sbrst_pkg::MIN_RST_CYC - 2;
    logic [15:0] low_cnt_r [5];
    logic [4:0] prev_r;
    logic short_w;
    // Counts sampled low cycles per pin; saturates so a long hold cannot wrap.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prev_r <= 5'h00;
            for (int i = 0; i < 5; i++) low_cnt_r[i] <= 16'h0000;
        end else begin
            prev_r <= slot_reset_out_n_o;
            for (int i = 0; i < 5; i++) begin
                if (slot_reset_out_n_o[i]) low_cnt_r[i] <= 16'h0000;
                else if (low_cnt_r[i] != 16'hFFFF) low_cnt_r[i] <= low_cnt_r[i] + 16'h0001;
            end
        end
    end
    // Flags a negation that comes before the minimum pulse width.
    always_comb begin
        short_w = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (slot_reset_out_n_o[i] && !prev_r[i] && low_cnt_r[i] < MIN_LOW) short_w = 1'b1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_up_link_kept: assert property ($past(nrst) |-> up_link_hold)
        else $error("upstream link hold dropped");
    a_oe_needs_alt: assert property ((slot_reset_out_n_oe & ~gpio_alt_en & ~$past(gpio_alt_en)) == 5'h00)
        else $error("reset pin driven without alternate function");
    a_reset_min_width: assert property (!short_w)
        else $error("reset pulse shorter than minimum");
    a_ts1_needs_link: assert property ((dn_ctl.hot_reset_ts1 & ~link_up & ~$past(link_up) & ~$past(link_up, 2)) == 5'h00)
        else $error("hot reset sets sent on a down link");
    a_flush_with_ur: assert property (dn_ctl.flush_queue == dn_ctl.ur_secondary)
        else $error("flush and unsupported marking differ");
    a_up_reset_all: assert property ((cfg_blocked != 5'h00 && $past(cfg_blocked) != 5'h00) |-> (dn_ctl.flush_queue == 5'h1F && dn_ctl.logic_reset == 5'h1F))
        else $error("upstream reset missed a port");
    a_block_all_ports: assert property (cfg_blocked == 5'h00 || cfg_blocked == 5'h1F)
        else $error("partial register block");
    a_power_off_order: assert property ((~slot_power_enable_out & $past(slot_power_enable_out) & slot_reset_out_n_o) == 5'h00)
        else $error("power dropped before reset asserted");
    c_up_reset: cover property (cfg_blocked == 5'h1F);
    c_rst_rise: cover property ($rose(slot_reset_out_n_o[0]));
    c_pe_fall: cover property ($fell(slot_power_enable_out[0]));
endmodule

bind sbrst_top sbrst_monitor u_mon (.core_clk(core_clk), .nrst(nrst), .hreadyout(hreadyout),
    .hresp(hresp), .link_up(link_up), .gpio_alt_en(gpio_alt_en),
    .slot_power_enable_out(slot_power_enable_out), .slot_reset_out_n_o(slot_reset_out_n_o),
    .slot_reset_out_n_oe(slot_reset_out_n_oe), .dn_ctl(dn_ctl), .up_link_hold(up_link_hold),
    .cfg_blocked(cfg_blocked));

// ===== sbrst_slot_model.sv
`timescale 1ns/100ps
// =====================================================================
// Slot supplies and reset pins beside the switch
// =====================================================================
module sbrst_slot_model #(
    parameter int PG_DLY = 100 // Supply ramp time in cycles.
) (
    input wire logic core_clk, // Core clock.
    input wire logic nrst, // Reset, active low.
    input wire logic [4:0] pwr_en, // Power enable from the switch.
    input wire logic [4:0] fault, // Forced supply fault.
    input wire logic [4:0] rst_o, // Reset pin level driven.
    input wire logic [4:0] rst_oe, // Reset pin enable.
    output logic [4:0] pg_n, // Power good, active low.
    output logic [4:0] rst_pin // Reset wire level.
);
    logic [7:0] ramp_r [5];
    // Supply ramps while enabled; a fault or disable drops it at once.
    always_ff @(posedge core_clk or negedge nrst) begin
        for (int i = 0; i < 5; i++) begin
            if (!nrst || !pwr_en[i] || fault[i]) ramp_r[i] <= 8'h00;
            else if (ramp_r[i] != 8'(PG_DLY)) ramp_r[i] <= ramp_r[i] + 8'h01;
        end
    end
    // Power good reported only after the ramp and without a fault.
    always_comb begin
        for (int i = 0; i < 5; i++) pg_n[i] = !(ramp_r[i] == 8'(PG_DLY) && !fault[i]);
    end
    // A pull-down holds an undriven reset wire asserted.
    assign rst_pin = rst_o & rst_oe;
endmodule

// ===== sbrst_top_tb.sv
`timescale 1ns/100ps
// =====================================================================
// Self-checking bench for the reset controller
// =====================================================================
module sbrst_top_tb;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} sbrst_row_t;
    logic core_clk, nrst, hsel, hwrite, hready, hreadyout, hresp, up_link_hold;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q;
    logic [4:0] link_up, pg_n, pe, n_o, oe, alt, blk, fault, pin;
    sbrst_pkg::sbrst_dn_ctl_t dn_ctl;
    int err_total, num_checks, n;
    sbrst_row_t rows [10] = '{'{0, 8'h08, 0, 32'h1F}, '{0, 8'h0C, 0, 0}, '{0, 8'h10, 0, 32'h1F000000},
        '{0, 8'h14, 0, 0}, '{1, 8'h14, 32'hA5A5A5A5, 0}, '{0, 8'h14, 0, 32'hA5A5A5A5},
        '{1, 8'h18, 32'hFFFFFFFF, 0}, '{0, 8'h18, 0, 0}, '{0, 8'h00, 0, 0}, '{0, 8'h04, 0, 0}};
    assign hready = hreadyout;
    sbrst_top dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link_up(link_up), .slot_power_good_n(pg_n),
        .slot_power_enable_out(pe), .slot_reset_out_n_o(n_o), .slot_reset_out_n_oe(oe),
        .gpio_alt_en(alt), .dn_ctl(dn_ctl), .up_link_hold(up_link_hold), .cfg_blocked(blk));
    sbrst_slot_model #(.PG_DLY(100)) u_slot (.core_clk(core_clk), .nrst(nrst), .pwr_en(pe),
        .fault(fault), .rst_o(n_o), .rst_oe(oe), .pg_n(pg_n), .rst_pin(pin));
    // Free-running 50 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_rng(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("[ERR] %0t delay %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // One single AHB transfer; the address phase holds until ready is seen.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // Cycles until a power enable (s=0) or reset pin (s=1) reaches v.
    task wait_sig(input int s, input int p, input logic v);
        n = 0;
        while ((s == 0 ? pe[p] : n_o[p]) !== v && n < 20000) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog sized well past the longest expected run.
    initial begin
        repeat (60000) @(posedge core_clk);
        err_total++;
        report_and_stop;
    end
    // Main sequence: register rows first, then the sequenced resets.
    initial begin
        err_total = 0; num_checks = 0;
        nrst = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
        link_up = 5'h15; alt = 0; fault = 0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk32({oe, pin, pe}, 15'h0000);
        foreach (rows[i]) begin
            xfer(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk32(q, rows[i].e);
        end
        alt <= 5'h1F;
        repeat (3) @(posedge core_clk);
        chk32({oe, pin}, {5'h1F, 5'h00});
        $display("test registers done");
        xfer(1, 8'h00, 1);
        repeat (3) @(posedge core_clk);
        chk32(dn_ctl, {5'h15, 5'h1F, 5'h1F, 5'h1F});
        chk32(blk, 5'h1F);
        xfer(1, 8'h14, 32'h12345678);
        xfer(0, 8'h14, 0);
        chk32(q, 0);
        xfer(0, 8'h00, 0);
        chk32(q[0], 1'b1);
        repeat (20) @(posedge core_clk);
        chk32({up_link_hold, dn_ctl}, {1'b1, 5'h15, 5'h1F, 5'h1F, 5'h1F});
        xfer(1, 8'h00, 0);
        repeat (3) @(posedge core_clk);
        chk32({blk, dn_ctl}, 0);
        xfer(0, 8'h14, 0);
        chk32(q, 0);
        $display("test upstream reset done");
        xfer(1, 8'h04, 6);
        repeat (3) @(posedge core_clk);
        chk32({blk, dn_ctl.hot_reset_ts1, dn_ctl.flush_queue, dn_ctl.ur_secondary}, 20'h010C6);
        xfer(0, 8'h04, 0);
        chk32(q, 6);
        xfer(1, 8'h04, 0);
        repeat (3) @(posedge core_clk);
        chk32(dn_ctl, 0);
        $display("test downstream reset done");
        repeat (10000) @(posedge core_clk);
        xfer(1, 8'h0C, 32'h00050A00);
        xfer(1, 8'h08, 32'h1E);
        wait_sig(0, 0, 1);
        chk_rng(n, 0, 3);
        wait_sig(1, 0, 1);
        chk_rng(n, 500, 504);
        xfer(1, 8'h08, 32'h1F);
        wait_sig(1, 0, 0);
        chk_rng(n, 2, 4);
        wait_sig(0, 0, 0);
        chk_rng(n, 248, 254);
        $display("test power enable mode done");
        xfer(1, 8'h0C, 32'h00050A01);
        xfer(1, 8'h08, 32'h1D);
        wait_sig(0, 1, 1);
        wait_sig(1, 1, 1);
        chk_rng(n, 600, 606);
        fault <= 5'h02;
        wait_sig(1, 1, 0);
        chk_rng(n, 2, 4);
        fault <= 5'h00;
        xfer(1, 8'h08, 32'h1F);
        $display("test power good mode done");
        xfer(1, 8'h0C, 32'h00050A02);
        xfer(1, 8'h04, 32'h10);
        repeat (3) @(posedge core_clk);
        chk32(n_o[4], 1'b0);
        xfer(1, 8'h04, 0);
        wait_sig(1, 4, 1);
        chk_rng(n, 9980, 10010);
        $display("test hot reset mode done");
        report_and_stop;
    end
endmodule
